//--- sespr_regs.vh
`ifndef SESPR_REGS_VH
`define SESPR_REGS_VH

// Register byte offsets on the APB side.
`define SESPR_OFF_CTRL 12'h000
`define SESPR_OFF_STATUS 12'h004
`define SESPR_OFF_MASK 12'h008
`define SESPR_OFF_HITS 12'h00C
`define SESPR_OFF_MISSES 12'h010

// Control register fields and reset values.
`define SESPR_CTRL_SUP_BIT 0
`define SESPR_CTRL_TBL_HI 8
`define SESPR_CTRL_TBL_LO 4
`define SESPR_RST_SUP 1'b1
`define SESPR_RST_TBL 5'h10
`define SESPR_TBL_MAX 5'h10

// Event bits, shared by status and mask.
`define SESPR_EV_W 4
`define SESPR_EV_CONFLICT 0
`define SESPR_EV_RANGE 1
`define SESPR_EV_BADENT 2
`define SESPR_EV_REWRITE 3

// Stream table entry field positions.
`define SESPR_ENT_W 128
`define SESPR_ENT_VALID 0
`define SESPR_ENT_CFG_HI 3
`define SESPR_ENT_CFG_LO 1
`define SESPR_ENT_DRP 76
`define SESPR_ENT_SPAN_HI 80
`define SESPR_ENT_SPAN_LO 77
`define SESPR_ENT_S1B_HI 97
`define SESPR_ENT_S1B_LO 96

// Configuration codes.
`define SESPR_CFG_BYPASS 3'h4
`define SESPR_CFG_S1ONLY 3'h5
`define SESPR_S1B_BYPASS 2'h1

// Transaction operation codes.
`define SESPR_OP_READ 3'h0
`define SESPR_OP_WRITE 3'h1
`define SESPR_OP_READ_INV 3'h2
`define SESPR_OP_CMO_INV 3'h3
`define SESPR_OP_CMO_CLEAN_INV 3'h4

`define SESPR_SID_W 16
`define SESPR_NUM_ENT 4
`define SESPR_PTR_W 2

`endif

//--- sespr_op_policy.v
`timescale 1ns/1ps
`include "sespr_regs.vh"

module sespr_op_policy (
  op,
  destructive_read_permit,
  cfg_code,
  stage1_bypass_select,
  page_ok,
  supported,
  out_op,
  rewritten
);
  input wire [2:0] op;
  input wire destructive_read_permit;
  input wire [2:0] cfg_code;
  input wire [1:0] stage1_bypass_select;
  input wire page_ok;
  input wire supported;
  output reg [2:0] out_op;
  output reg rewritten;

  reg all_bypass;
  reg allow;

  always @* begin
    all_bypass = (cfg_code == `SESPR_CFG_BYPASS) ||
                 ((cfg_code == `SESPR_CFG_S1ONLY) &&
                  (stage1_bypass_select == `SESPR_S1B_BYPASS));
    // An unsupported implementation ignores the permit bit and passes destructive forms only in bypass.
    allow = all_bypass || (supported && destructive_read_permit && page_ok);
    out_op = op;
    rewritten = 1'b0;
    if (!allow) begin
      if (op == `SESPR_OP_READ_INV) begin
        out_op = `SESPR_OP_READ;
        rewritten = 1'b1;
      end else if (op == `SESPR_OP_CMO_INV) begin
        out_op = `SESPR_OP_CMO_CLEAN_INV;
        rewritten = 1'b1;
      end
    end
  end
endmodule // sespr_op_policy

//--- sespr_top.v
// Functional notes
// - Permit clear turns read-invalidate into read.
// - Permit clear turns invalidate into clean-invalidate.
// - Permit set lets read-invalidate pass destructively.
// - Permit set forwards invalidate unchanged.
// - Destructive forms also need page permission.
// - Unsupported implementation ignores the permit bit.
// - Permit applies only when a stage translates.
// - Span hint is entry bits 80 to 77.
// - Span hint zero matches only its own stream.
// - Span covers 2^N streams, aligned base.
// - Cached entry matches any stream in span.
// - Invalidation hits only the targeted entry.
// - Differing span entries report conflict and abort.
// - Span larger than table is capped.
// - Permit bit is entry bit 76.
// - Streams beyond the table never match.
`timescale 1ns/1ps
`include "sespr_regs.vh"

module sespr_top (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire req_valid,
  output reg req_ready,
  input wire [15:0] req_sid,
  input wire [2:0] req_op,
  input wire req_page_ok,
  output reg out_valid,
  output reg [15:0] out_sid,
  output reg [2:0] out_op,
  output reg out_abort,
  output reg fetch_req,
  output reg [15:0] fetch_sid,
  input wire fetch_valid,
  input wire [127:0] fetch_entry,
  input wire cfgi_valid,
  input wire cfgi_all,
  input wire [15:0] cfgi_sid
);
  localparam ST_IDLE = 2'b00;
  localparam ST_CHECK = 2'b01;
  localparam ST_WAIT = 2'b10;

  // Mask that keeps the stream bits above a span of 2^e entries.
  function [15:0] span_mask;
    input [4:0] e;
    reg [16:0] ones;
    begin
      ones = (17'h00001 << e) - 17'h00001;
      span_mask = ~ones[15:0];
    end
  endfunction

  // True when stream b lies in the span of stream a, capped at the table size.
  function span_match;
    input [15:0] a;
    input [15:0] b;
    input [3:0] span;
    input [4:0] tbl;
    reg [4:0] eff;
    begin
      eff = ({1'b0, span} > tbl) ? tbl : {1'b0, span};
      span_match = (((a ^ b) & span_mask(eff)) == 16'h0000);
    end
  endfunction

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg sup_ff;
  reg [4:0] tbl_ff;
  reg [`SESPR_EV_W-1:0] status_ff;
  reg [`SESPR_EV_W-1:0] mask_ff;
  reg [31:0] hits_ff;
  reg [31:0] misses_ff;
  reg [15:0] cur_sid_ff;
  reg [2:0] cur_op_ff;
  reg cur_page_ok_ff;
  reg [`SESPR_PTR_W-1:0] fill_ptr_ff;
  reg [`SESPR_NUM_ENT-1:0] ent_vld_ff;
  reg [15:0] ent_tag_ff [0:`SESPR_NUM_ENT-1];
  reg [3:0] ent_span_ff [0:`SESPR_NUM_ENT-1];
  reg ent_drp_ff [0:`SESPR_NUM_ENT-1];
  reg [2:0] ent_cfg_ff [0:`SESPR_NUM_ENT-1];
  reg [1:0] ent_s1b_ff [0:`SESPR_NUM_ENT-1];

  wire [3:0] f_span = fetch_entry[`SESPR_ENT_SPAN_HI:`SESPR_ENT_SPAN_LO];
  wire f_drp = fetch_entry[`SESPR_ENT_DRP];
  wire [2:0] f_cfg = fetch_entry[`SESPR_ENT_CFG_HI:`SESPR_ENT_CFG_LO];
  wire [1:0] f_s1b = fetch_entry[`SESPR_ENT_S1B_HI:`SESPR_ENT_S1B_LO];
  wire f_valid = fetch_entry[`SESPR_ENT_VALID];

  wire [`SESPR_NUM_ENT-1:0] hit_vec;
  wire [`SESPR_NUM_ENT-1:0] conf_vec;
  wire [`SESPR_NUM_ENT-1:0] inv_vec;

  genvar gi;
  generate
    for (gi = 0; gi < `SESPR_NUM_ENT; gi = gi + 1) begin : g_ent
      assign hit_vec[gi] = ent_vld_ff[gi] &&
                           span_match(ent_tag_ff[gi], cur_sid_ff, ent_span_ff[gi], tbl_ff);
      // The new entry's span covers a cached neighbour whose fields differ.
      assign conf_vec[gi] = ent_vld_ff[gi] &&
                            span_match(cur_sid_ff, ent_tag_ff[gi], f_span, tbl_ff) &&
                            ((ent_drp_ff[gi] != f_drp) || (ent_cfg_ff[gi] != f_cfg) ||
                             (ent_s1b_ff[gi] != f_s1b));
      assign inv_vec[gi] = cfgi_valid && (cfgi_all || (ent_tag_ff[gi] == cfgi_sid));
    end
  endgenerate

  // Select the lowest hitting entry.
  reg [`SESPR_PTR_W-1:0] hit_idx;
  integer k;
  always @* begin
    hit_idx = {`SESPR_PTR_W{1'b0}};
    for (k = `SESPR_NUM_ENT - 1; k >= 0; k = k - 1) begin
      if (hit_vec[k]) begin
        hit_idx = k[`SESPR_PTR_W-1:0];
      end
    end
  end

  wire out_of_range = ((cur_sid_ff & span_mask(tbl_ff)) != 16'h0000);
  wire any_hit = |hit_vec;
  wire any_conf = |conf_vec;

  wire in_wait_done = (state_ff == ST_WAIT) && fetch_valid;
  wire pol_drp = in_wait_done ? f_drp : ent_drp_ff[hit_idx];
  wire [2:0] pol_cfg = in_wait_done ? f_cfg : ent_cfg_ff[hit_idx];
  wire [1:0] pol_s1b = in_wait_done ? f_s1b : ent_s1b_ff[hit_idx];
  wire [2:0] pol_op;
  wire pol_rewritten;

  sespr_op_policy u_policy (
    .op(cur_op_ff),
    .destructive_read_permit(pol_drp),
    .cfg_code(pol_cfg),
    .stage1_bypass_select(pol_s1b),
    .page_ok(cur_page_ok_ff),
    .supported(sup_ff),
    .out_op(pol_op),
    .rewritten(pol_rewritten)
  );

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          nxt_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!out_of_range && !any_hit) begin
          nxt_state = ST_WAIT;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (fetch_valid) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Events raised by the translation path this cycle.
  reg [`SESPR_EV_W-1:0] ev_set;
  always @* begin
    ev_set = {`SESPR_EV_W{1'b0}};
    if (state_ff == ST_CHECK && out_of_range) begin
      ev_set[`SESPR_EV_RANGE] = 1'b1;
    end
    if (state_ff == ST_CHECK && !out_of_range && any_hit && pol_rewritten) begin
      ev_set[`SESPR_EV_REWRITE] = 1'b1;
    end
    if (in_wait_done) begin
      if (!f_valid) begin
        ev_set[`SESPR_EV_BADENT] = 1'b1;
      end else if (any_conf) begin
        ev_set[`SESPR_EV_CONFLICT] = 1'b1;
      end else if (pol_rewritten) begin
        ev_set[`SESPR_EV_REWRITE] = 1'b1;
      end
    end
  end

  wire apb_setup_done = psel && penable && !pready;
  wire apb_done = psel && penable && pready;
  wire apb_wr = apb_done && pwrite;
  wire rd_status = apb_done && !pwrite && (paddr == `SESPR_OFF_STATUS);
  wire addr_ok = (paddr == `SESPR_OFF_CTRL) || (paddr == `SESPR_OFF_STATUS) ||
                 (paddr == `SESPR_OFF_MASK) || (paddr == `SESPR_OFF_HITS) ||
                 (paddr == `SESPR_OFF_MISSES);

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `SESPR_OFF_CTRL: begin
        rd_mux[`SESPR_CTRL_SUP_BIT] = sup_ff;
        rd_mux[`SESPR_CTRL_TBL_HI:`SESPR_CTRL_TBL_LO] = tbl_ff;
      end
      `SESPR_OFF_STATUS: rd_mux[`SESPR_EV_W-1:0] = status_ff;
      `SESPR_OFF_MASK: rd_mux[`SESPR_EV_W-1:0] = mask_ff;
      `SESPR_OFF_HITS: rd_mux = hits_ff;
      `SESPR_OFF_MISSES: rd_mux = misses_ff;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      sup_ff <= `SESPR_RST_SUP;
      tbl_ff <= `SESPR_RST_TBL;
      mask_ff <= {`SESPR_EV_W{1'b0}};
      status_ff <= {`SESPR_EV_W{1'b0}};
      irq <= 1'b0;
    end else begin
      pready <= apb_setup_done;
      if (apb_setup_done) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= !addr_ok;
      end
      if (apb_wr && paddr == `SESPR_OFF_CTRL) begin
        sup_ff <= pwdata[`SESPR_CTRL_SUP_BIT];
        // A table larger than the stream number space is held at the maximum.
        tbl_ff <= (pwdata[`SESPR_CTRL_TBL_HI:`SESPR_CTRL_TBL_LO] > `SESPR_TBL_MAX) ?
                  `SESPR_TBL_MAX : pwdata[`SESPR_CTRL_TBL_HI:`SESPR_CTRL_TBL_LO];
      end
      if (apb_wr && paddr == `SESPR_OFF_MASK) begin
        mask_ff <= pwdata[`SESPR_EV_W-1:0];
      end
      // A read clears only the bits it reported, so an event that lands between the
      // data capture and the access edge is kept; a new event also wins over the clear.
      status_ff <= (status_ff & ~(rd_status ? prdata[`SESPR_EV_W-1:0] : {`SESPR_EV_W{1'b0}})) |
                   ev_set;
      irq <= |(((status_ff & ~(rd_status ? prdata[`SESPR_EV_W-1:0] : {`SESPR_EV_W{1'b0}})) |
                ev_set) & mask_ff);
    end
  end

  integer j;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      req_ready <= 1'b1;
      cur_sid_ff <= 16'h0000;
      cur_op_ff <= `SESPR_OP_READ;
      cur_page_ok_ff <= 1'b0;
      out_valid <= 1'b0;
      out_sid <= 16'h0000;
      out_op <= `SESPR_OP_READ;
      out_abort <= 1'b0;
      fetch_req <= 1'b0;
      fetch_sid <= 16'h0000;
      fill_ptr_ff <= {`SESPR_PTR_W{1'b0}};
      hits_ff <= 32'h00000000;
      misses_ff <= 32'h00000000;
      ent_vld_ff <= {`SESPR_NUM_ENT{1'b0}};
      for (j = 0; j < `SESPR_NUM_ENT; j = j + 1) begin
        ent_tag_ff[j] <= 16'h0000;
        ent_span_ff[j] <= 4'h0;
        ent_drp_ff[j] <= 1'b0;
        ent_cfg_ff[j] <= 3'h0;
        ent_s1b_ff[j] <= 2'h0;
      end
    end else begin
      state_ff <= nxt_state;
      out_valid <= 1'b0;
      // Each command drops only entries it names, never whole spans.
      ent_vld_ff <= ent_vld_ff & ~inv_vec;
      case (state_ff)
        ST_IDLE: begin
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            cur_sid_ff <= req_sid;
            cur_op_ff <= req_op;
            cur_page_ok_ff <= req_page_ok;
          end
        end
        ST_CHECK: begin
          out_sid <= cur_sid_ff;
          if (out_of_range) begin
            out_valid <= 1'b1;
            out_abort <= 1'b1;
            out_op <= cur_op_ff;
            req_ready <= 1'b1;
          end else if (any_hit) begin
            out_valid <= 1'b1;
            out_abort <= 1'b0;
            out_op <= pol_op;
            hits_ff <= hits_ff + 32'h00000001;
            req_ready <= 1'b1;
          end else begin
            fetch_req <= 1'b1;
            fetch_sid <= cur_sid_ff;
            misses_ff <= misses_ff + 32'h00000001;
          end
        end
        ST_WAIT: begin
          if (fetch_valid) begin
            fetch_req <= 1'b0;
            out_valid <= 1'b1;
            req_ready <= 1'b1;
            out_op <= pol_op;
            // A conflicting or invalid entry aborts and is not cached.
            out_abort <= !f_valid || any_conf;
            if (f_valid && !any_conf) begin
              ent_vld_ff[fill_ptr_ff] <= 1'b1;
              ent_tag_ff[fill_ptr_ff] <= cur_sid_ff;
              ent_span_ff[fill_ptr_ff] <= f_span;
              ent_drp_ff[fill_ptr_ff] <= f_drp;
              ent_cfg_ff[fill_ptr_ff] <= f_cfg;
              ent_s1b_ff[fill_ptr_ff] <= f_s1b;
              fill_ptr_ff <= fill_ptr_ff + {{(`SESPR_PTR_W-1){1'b0}}, 1'b1};
            end
          end
        end
        default: begin
          req_ready <= 1'b1;
          fetch_req <= 1'b0;
        end
      endcase
    end
  end
endmodule // sespr_top

//--- sespr_chk.sv
`timescale 1ns/1ps
`include "sespr_regs.vh"
module sespr_chk (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire req_valid,
  input wire req_ready,
  input wire [15:0] req_sid,
  input wire [2:0] req_op,
  input wire out_valid,
  input wire [15:0] out_sid,
  input wire [2:0] out_op,
  input wire fetch_req,
  input wire [15:0] fetch_sid,
  input wire fetch_valid
);
  reg [15:0] sid_ff;
  reg [2:0] op_ff;
  // The accepted request is kept so that each result can be tied to its cause.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sid_ff <= 16'h0000;
      op_ff <= 3'h0;
    end else if (req_valid && req_ready) begin
      sid_ff <= req_sid;
      op_ff <= req_op;
    end
  end
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_acc; req_valid && req_ready; endsequence
  sequence s_fill; fetch_req && fetch_valid; endsequence
  property p_apb_ans; psel && penable && !pready |=> pready; endproperty
  property p_slverr; pready |-> pslverr == !(paddr inside {`SESPR_OFF_CTRL,
    `SESPR_OFF_STATUS, `SESPR_OFF_MASK, `SESPR_OFF_HITS, `SESPR_OFF_MISSES}); endproperty
  property p_step; s_acc |=> !req_ready ##1 (out_valid || fetch_req); endproperty
  property p_hold; fetch_req && !fetch_valid |=> fetch_req && $stable(fetch_sid); endproperty
  property p_fill; s_fill |=> out_valid && !fetch_req && req_ready; endproperty
  property p_fsid; $rose(fetch_req) |-> fetch_sid == sid_ff; endproperty
  property p_sid; out_valid |-> out_sid == sid_ff; endproperty
  property p_keep; out_valid && op_ff != `SESPR_OP_READ_INV && op_ff != `SESPR_OP_CMO_INV
    |-> out_op == op_ff; endproperty
  property p_rdinv; out_valid && op_ff == `SESPR_OP_READ_INV
    |-> out_op inside {`SESPR_OP_READ, `SESPR_OP_READ_INV}; endproperty
  property p_cmo; out_valid && op_ff == `SESPR_OP_CMO_INV
    |-> out_op inside {`SESPR_OP_CMO_INV, `SESPR_OP_CMO_CLEAN_INV}; endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("APB answer late");
  a_slverr: assert property (p_slverr) else $error("APB error flag wrong");
  a_step: assert property (p_step) else $error("lookup step late");
  a_hold: assert property (p_hold) else $error("fetch dropped early");
  a_fill: assert property (p_fill) else $error("fill result late");
  a_fsid: assert property (p_fsid) else $error("fetch stream wrong");
  a_sid: assert property (p_sid) else $error("result stream wrong");
  a_keep: assert property (p_keep) else $error("plain op altered");
  a_rdinv: assert property (p_rdinv) else $error("read-inv mapped wrong");
  a_cmo: assert property (p_cmo) else $error("invalidate mapped wrong");
endmodule // sespr_chk

bind sespr_top sespr_chk chk_u (.ref_clk, .rst, .psel, .penable, .paddr, .pready, .pslverr,
  .req_valid, .req_ready, .req_sid, .req_op, .out_valid, .out_sid, .out_op, .fetch_req,
  .fetch_sid, .fetch_valid);

//--- sespr_mem.sv
`timescale 1ns/1ps
module sespr_mem (
  input wire ref_clk,
  input wire rst,
  input wire [3:0] lat,
  input wire fetch_req,
  input wire [15:0] fetch_sid,
  output reg fetch_valid,
  output reg [127:0] fetch_entry
);
  reg [127:0] tbl [0:15];
  reg [3:0] cnt_ff;
  // Idle entry lines toggle, so a capture outside the valid pulse never looks right.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_valid <= 1'h0;
      fetch_entry <= 128'h0;
      cnt_ff <= 4'h0;
    end else begin
      fetch_valid <= 1'h0;
      fetch_entry <= ~fetch_entry;
      if (fetch_req && !fetch_valid) begin
        if (cnt_ff == lat) begin
          fetch_valid <= 1'h1;
          fetch_entry <= tbl[fetch_sid[3:0]];
          cnt_ff <= 4'h0;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
endmodule // sespr_mem

//--- sespr_tb.sv
`timescale 1ns/1ps
`include "sespr_regs.vh"
module tb;
  reg ref_clk = 1'h0;
  reg rst = 1'h1;
  reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0, req_valid = 1'h0, req_page_ok = 1'h0;
  reg cfgi_valid = 1'h0, cfgi_all = 1'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [15:0] req_sid = 16'h0000, cfgi_sid = 16'h0000;
  reg [2:0] req_op = 3'h0;
  reg [3:0] lat = 4'h0;
  reg er;
  wire [31:0] prdata;
  wire pready, pslverr, irq, req_ready, out_valid, out_abort, fetch_req, fetch_valid;
  wire [15:0] out_sid, fetch_sid;
  wire [2:0] out_op;
  wire [127:0] fetch_entry;
  int fail_count = 0, n_checks = 0, nf = 0, n0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (fetch_req && fetch_valid) nf++;
  sespr_top dut_u (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .req_valid, .req_ready, .req_sid, .req_op, .req_page_ok, .out_valid,
    .out_sid, .out_op, .out_abort, .fetch_req, .fetch_sid, .fetch_valid, .fetch_entry,
    .cfgi_valid, .cfgi_all, .cfgi_sid);
  sespr_mem mem_u (.ref_clk, .rst, .lat, .fetch_req, .fetch_sid, .fetch_valid, .fetch_entry);
  task automatic chk(input [31:0] g, input [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input w, input [11:0] a, input [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do @(posedge ref_clk); while (pready !== 1'h1 && n++ < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask
  task automatic tx(input [15:0] s, input [2:0] o, input p, input [2:0] eo, input ea);
    int n;
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req_sid <= s;
    req_op <= o;
    req_page_ok <= p;
    n = 0;
    do @(posedge ref_clk); while (req_ready !== 1'h1 && n++ < 50);
    req_valid <= 1'h0;
    do @(posedge ref_clk); while (out_valid !== 1'h1 && n++ < 100);
    if (n >= 100) chk(32'h0, 32'h1);
    chk({28'h0, out_abort, out_op}, {28'h0, ea, eo});
  endtask
  task automatic inv(input a, input [15:0] s);
    @(posedge ref_clk);
    cfgi_valid <= 1'h1;
    cfgi_all <= a;
    cfgi_sid <= s;
    @(posedge ref_clk);
    cfgi_valid <= 1'h0;
  endtask
  // Stream table entries are placed straight into the partner's memory.
  task automatic put(input [3:0] i, input pm, input [3:0] sp, input [2:0] cf, input [1:0] sb);
    mem_u.tbl[i] = {30'h0, sb, 15'h0, sp, pm, 72'h0, cf, 1'h1};
  endtask
  task automatic t_regs;
    apb(1'h0, `SESPR_OFF_CTRL, 32'h0);
    chk(rd, 32'h00000101);
    apb(1'h0, `SESPR_OFF_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, `SESPR_OFF_CTRL, 32'h000001F1);
    apb(1'h0, `SESPR_OFF_CTRL, 32'h0);
    chk(rd, 32'h00000101);
    apb(1'h0, 12'h014, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask
  task automatic t_policy;
    put(4'h0, 1'h0, 4'h0, `SESPR_CFG_S1ONLY, 2'h0);
    put(4'h1, 1'h1, 4'h0, `SESPR_CFG_S1ONLY, 2'h0);
    put(4'h2, 1'h0, 4'h0, `SESPR_CFG_BYPASS, 2'h0);
    put(4'h3, 1'h0, 4'h0, `SESPR_CFG_S1ONLY, `SESPR_S1B_BYPASS);
    tx(16'h0, `SESPR_OP_READ_INV, 1'h1, `SESPR_OP_READ, 1'h0);
    tx(16'h0, `SESPR_OP_CMO_INV, 1'h1, `SESPR_OP_CMO_CLEAN_INV, 1'h0);
    tx(16'h0, `SESPR_OP_WRITE, 1'h1, `SESPR_OP_WRITE, 1'h0);
    tx(16'h1, `SESPR_OP_READ_INV, 1'h1, `SESPR_OP_READ_INV, 1'h0);
    tx(16'h1, `SESPR_OP_CMO_INV, 1'h1, `SESPR_OP_CMO_INV, 1'h0);
    tx(16'h1, `SESPR_OP_READ_INV, 1'h0, `SESPR_OP_READ, 1'h0);
    tx(16'h2, `SESPR_OP_READ_INV, 1'h0, `SESPR_OP_READ_INV, 1'h0);
    tx(16'h3, `SESPR_OP_CMO_INV, 1'h0, `SESPR_OP_CMO_INV, 1'h0);
    apb(1'h1, `SESPR_OFF_CTRL, 32'h00000100);
    tx(16'h1, `SESPR_OP_READ_INV, 1'h1, `SESPR_OP_READ, 1'h0);
    apb(1'h1, `SESPR_OFF_CTRL, 32'h00000101);
  endtask
  task automatic t_span;
    inv(1'h1, 16'h0);
    lat <= 4'h3;
    for (int i = 8; i < 12; i++) put(i[3:0], 1'h1, 4'h2, `SESPR_CFG_S1ONLY, 2'h0);
    put(4'hC, 1'h0, 4'h0, `SESPR_CFG_S1ONLY, 2'h0);
    put(4'h4, 1'h1, 4'h0, `SESPR_CFG_S1ONLY, 2'h0);
    put(4'h5, 1'h1, 4'h0, `SESPR_CFG_S1ONLY, 2'h0);
    put(4'hE, 1'h0, 4'h3, `SESPR_CFG_S1ONLY, 2'h0);
    n0 = nf;
    for (int i = 9; i > 7; i--) tx(i[15:0], `SESPR_OP_READ, 1'h1, `SESPR_OP_READ, 1'h0);
    tx(16'hB, `SESPR_OP_READ_INV, 1'h1, `SESPR_OP_READ_INV, 1'h0);
    chk(nf, n0 + 1);
    tx(16'hC, `SESPR_OP_READ_INV, 1'h1, `SESPR_OP_READ, 1'h0);
    tx(16'h4, `SESPR_OP_READ, 1'h1, `SESPR_OP_READ, 1'h0);
    tx(16'h5, `SESPR_OP_READ, 1'h1, `SESPR_OP_READ, 1'h0);
    chk(nf, n0 + 4);
    inv(1'h0, 16'h9);
    tx(16'h4, `SESPR_OP_READ, 1'h1, `SESPR_OP_READ, 1'h0);
    tx(16'hA, `SESPR_OP_READ, 1'h1, `SESPR_OP_READ, 1'h0);
    chk(nf, n0 + 5);
  endtask
  task automatic t_conflict;
    apb(1'h0, `SESPR_OFF_STATUS, 32'h0);
    apb(1'h1, `SESPR_OFF_MASK, 32'h0);
    tx(16'hE, `SESPR_OP_READ, 1'h1, `SESPR_OP_READ, 1'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, `SESPR_OFF_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h0, `SESPR_OFF_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_range;
    apb(1'h1, `SESPR_OFF_CTRL, 32'h00000041);
    inv(1'h1, 16'h0);
    put(4'h0, 1'h1, 4'hF, `SESPR_CFG_S1ONLY, 2'h0);
    // An entry without its valid bit must abort and never be cached.
    mem_u.tbl[4'h1] = 128'h0;
    tx(16'h1, `SESPR_OP_READ, 1'h1, `SESPR_OP_READ, 1'h1);
    n0 = nf;
    tx(16'h0, `SESPR_OP_READ_INV, 1'h1, `SESPR_OP_READ_INV, 1'h0);
    tx(16'hF, `SESPR_OP_READ_INV, 1'h1, `SESPR_OP_READ_INV, 1'h0);
    tx(16'h10, `SESPR_OP_READ, 1'h1, `SESPR_OP_READ, 1'h1);
    chk(nf, n0 + 1);
    apb(1'h0, `SESPR_OFF_STATUS, 32'h0);
    chk(rd, 32'h00000006);
    apb(1'h0, `SESPR_OFF_HITS, 32'h0);
    chk(rd, 32'h00000009);
    apb(1'h0, `SESPR_OFF_MISSES, 32'h0);
    chk(rd, 32'h0000000C);
    apb(1'h1, `SESPR_OFF_CTRL, 32'h00000101);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    t_regs;
    t_policy;
    t_span;
    t_conflict;
    t_range;
    tally_and_finish;
  end
  // The tests need well under two thousand cycles; ten times that means a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish;
  end
endmodule // tb
